// >>> pkg/flash_host_pkg.sv
// Constants, encodings and timing for the parallel flash host controller
package flash_host_pkg;

   // =====================================================================
   // Clock and pin timing
   localparam int CLK_MHZ = 100;
   localparam int T_SETUP_NS = 20;
   localparam int T_WP_NS = 50;
   localparam int T_HOLD_NS = 30;
   localparam int T_ACC_NS = 120;
   localparam int T_RST_WAIT_US = 10;
   localparam int SYNC_LAT = 2;
   // Least times round up to whole cycles
   localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
   localparam int HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
   localparam int RD_CYC = ACC_CYC + SYNC_LAT + 1;
   localparam int RST_WAIT_CYC = T_RST_WAIT_US * CLK_MHZ;
   localparam int TIMER_W = 10;

   // =====================================================================
   // Widths
   localparam int FLASH_ADDR_W = 18;
   localparam int FLASH_DATA_W = 16;

   // =====================================================================
   // Register map (byte offsets) and fields
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_CFG = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_RDATA = 8'h14;
   localparam int CFG_WORD_BIT = 0;
   localparam int CFG_UNLOCK_RST_BIT = 1;
   localparam logic [1:0] CFG_RESET = 2'h0;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_SETTLE_BIT = 1;
   localparam int ST_ERASE_BIT = 2;

   // =====================================================================
   // AHB-Lite encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;

   // =====================================================================
   // Flash command bytes and unlock addresses
   localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
   localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
   localparam logic [7:0] CMD_RESET = 8'hF0;
   localparam logic [7:0] CMD_IDENT = 8'h90;
   localparam logic [7:0] CMD_PROGRAM = 8'hA0;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
   localparam logic [7:0] CMD_BLOCK_CONFIRM = 8'h30;
   localparam logic [7:0] CMD_CHIP_CONFIRM = 8'h10;
   localparam logic [17:0] ADDR_BYTE_UNLOCK1 = 18'h0_AAAA;
   localparam logic [17:0] ADDR_BYTE_UNLOCK2 = 18'h0_5555;
   localparam logic [17:0] ADDR_WORD_UNLOCK1 = 18'h0_5555;
   localparam logic [17:0] ADDR_WORD_UNLOCK2 = 18'h0_2AAA;

   // =====================================================================
   // Sequence slots: two unlocks, command, two unlocks, final write
   localparam logic [2:0] STEP_UNLOCK1 = 3'h0;
   localparam logic [2:0] STEP_UNLOCK2 = 3'h1;
   localparam logic [2:0] STEP_CMD = 3'h2;
   localparam logic [2:0] STEP_UNLOCK3 = 3'h3;
   localparam logic [2:0] STEP_UNLOCK4 = 3'h4;
   localparam logic [2:0] STEP_FINAL = 3'h5;
   localparam logic [2:0] STEP_DONE = 3'h7;

   // Operations software can order
   typedef enum logic [2:0] {
      OP_READ = 3'h0,
      OP_RESET = 3'h1,
      OP_IDENT = 3'h2,
      OP_PROGRAM = 3'h3,
      OP_BLOCK_ERASE = 3'h4,
      OP_ERASE_ADD = 3'h5,
      OP_CHIP_ERASE = 3'h6,
      OP_RAW_WRITE = 3'h7
   } op_t;

   // Bus cycle states, Gray along setup-strobe-hold
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SETUP = 3'b001,
      ST_STROBE = 3'b011,
      ST_HOLD = 3'b010,
      ST_RD_WAIT = 3'b110,
      ST_SETTLE = 3'b100
   } state_t;

endpackage

// >>> logic/pin_sync.sv
// Two-stage synchroniser for a bus of pin inputs
`timescale 1ns/1ns
module pin_sync #(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pins in, synchronised out
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule

// >>> logic/flash_host_ctrl.sv
// Host controller that drives a parallel NOR flash command interface from AHB-Lite
//
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ns
// =========================================================================
module flash_host_ctrl
   import flash_host_pkg::*;
#(
   parameter int ADDR_W = FLASH_ADDR_W,
   parameter int DATA_W = FLASH_DATA_W
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Flash pins
   output logic [ADDR_W-1:0] flash_addr,
   output logic [DATA_W-1:0] flash_dq_out,
   output logic flash_dq_oe_n,
   input wire logic [DATA_W-1:0] flash_dq_in,
   output logic flash_ce_n,
   output logic flash_we_n,
   output logic flash_oe_n,
   output logic flash_byte_n
);

   // ======================================================================
   // Sequence decoding
   function automatic logic [2:0] first_step(input op_t op, input logic unlock_rst);
      case (op)
         OP_RESET: first_step = unlock_rst ? STEP_UNLOCK1 : STEP_CMD;
         OP_ERASE_ADD, OP_RAW_WRITE: first_step = STEP_FINAL;
         default: first_step = STEP_UNLOCK1;
      endcase
   endfunction

   function automatic logic [2:0] next_step(input op_t op, input logic [2:0] step);
      if (step == STEP_FINAL) begin
         next_step = STEP_DONE;
      end else if (step == STEP_CMD && op == OP_PROGRAM) begin
         next_step = STEP_FINAL;
      end else if (step == STEP_CMD && (op == OP_RESET || op == OP_IDENT)) begin
         next_step = STEP_DONE;
      end else begin
         next_step = step + 3'h1;
      end
   endfunction

   function automatic logic [ADDR_W-1:0] cyc_addr(input logic [2:0] step, input logic word,
                                                  input op_t op, input logic [ADDR_W-1:0] user);
      case (step)
         STEP_UNLOCK1, STEP_UNLOCK3, STEP_CMD:
            cyc_addr = ADDR_W'(word ? ADDR_WORD_UNLOCK1 : ADDR_BYTE_UNLOCK1);
         STEP_UNLOCK2, STEP_UNLOCK4:
            cyc_addr = ADDR_W'(word ? ADDR_WORD_UNLOCK2 : ADDR_BYTE_UNLOCK2);
         default:
            cyc_addr = (op == OP_CHIP_ERASE) ?
                       ADDR_W'(word ? ADDR_WORD_UNLOCK1 : ADDR_BYTE_UNLOCK1) : user;
      endcase
   endfunction

   function automatic logic [DATA_W-1:0] cyc_data(input logic [2:0] step, input op_t op,
                                                  input logic [DATA_W-1:0] wdata);
      logic [7:0] c;
      c = CMD_RESET;
      case (step)
         STEP_UNLOCK1, STEP_UNLOCK3: c = CMD_UNLOCK1;
         STEP_UNLOCK2, STEP_UNLOCK4: c = CMD_UNLOCK2;
         STEP_CMD: begin
            case (op)
               OP_IDENT: c = CMD_IDENT;
               OP_PROGRAM: c = CMD_PROGRAM;
               OP_BLOCK_ERASE, OP_CHIP_ERASE: c = CMD_ERASE_SETUP;
               default: c = CMD_RESET;
            endcase
         end
         default: begin
            case (op)
               OP_CHIP_ERASE: c = CMD_CHIP_CONFIRM;
               default: c = CMD_BLOCK_CONFIRM;
            endcase
         end
      endcase
      if (step == STEP_FINAL && (op == OP_PROGRAM || op == OP_RAW_WRITE)) begin
         cyc_data = wdata;
      end else begin
         cyc_data = DATA_W'(c);
      end
   endfunction

   // ======================================================================
   // State
   state_t state_q, state_d;
   op_t op_q, op_d;
   logic [2:0] step_q, step_d;
   logic [TIMER_W-1:0] timer_q, timer_d;
   logic erase_q, erase_d;
   logic [ADDR_W-1:0] addr_reg_q, addr_reg_d;
   logic [DATA_W-1:0] wdata_q, wdata_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic [1:0] cfg_q, cfg_d;
   logic wr_pend_q, wr_pend_d;
   logic [7:0] addr_lat_q, addr_lat_d;
   logic [31:0] hrdata_q, hrdata_d;
   logic [ADDR_W-1:0] fa_q, fa_d;
   logic [DATA_W-1:0] fdq_q, fdq_d;
   logic fdq_oe_n_q, fdq_oe_n_d;
   logic ce_n_q, ce_n_d;
   logic we_n_q, we_n_d;
   logic oe_n_q, oe_n_d;
   logic [DATA_W-1:0] dq_sync;
   logic accept;
   logic [2:0] nxt;

   // Data pins come from another timing domain
   pin_sync #(.WIDTH(DATA_W)) u_dq_sync (
      .clk(hclk),
      .rst_n(hresetn),
      .async_in(flash_dq_in),
      .sync_out(dq_sync)
   );

   // Transfer is taken only on a selected NONSEQ with bus ready
   assign accept = hsel && hready && (htrans == HTRANS_NONSEQ);

   // ======================================================================
   // Next-state logic for the bus slave, the sequencer and the pins
   always_comb begin
      state_d = state_q;
      op_d = op_q;
      step_d = step_q;
      timer_d = timer_q;
      erase_d = erase_q;
      addr_reg_d = addr_reg_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      cfg_d = cfg_q;
      hrdata_d = hrdata_q;
      wr_pend_d = accept && hwrite;
      addr_lat_d = accept ? haddr[7:0] : addr_lat_q;
      nxt = next_step(op_q, step_q);
      // Read data registered at the address phase, standing in the data phase
      if (accept && !hwrite) begin
         case (haddr[7:0])
            REG_ADDR: hrdata_d = 32'(addr_reg_q);
            REG_WDATA: hrdata_d = 32'(wdata_q);
            REG_CFG: hrdata_d = 32'(cfg_q);
            REG_STATUS: hrdata_d = 32'({erase_q, state_q == ST_SETTLE, state_q != ST_IDLE});
            REG_RDATA: hrdata_d = 32'(rdata_q);
            default: hrdata_d = 32'h0000_0000;
         endcase
      end
      // Sequencer; a command while busy is dropped, keeping sequences whole
      case (state_q)
         ST_IDLE: begin
            if (wr_pend_q && addr_lat_q == REG_CMD) begin
               op_d = op_t'(hwdata[2:0]);
               if (op_d == OP_READ) begin
                  state_d = ST_RD_WAIT;
                  timer_d = TIMER_W'(RD_CYC - 1);
               end else begin
                  step_d = first_step(op_d, cfg_q[CFG_UNLOCK_RST_BIT]);
                  state_d = ST_SETUP;
                  timer_d = TIMER_W'(SETUP_CYC - 1);
               end
            end
         end
         ST_SETUP: begin
            timer_d = timer_q - 1'b1;
            if (timer_q == '0) begin
               state_d = ST_STROBE;
               timer_d = TIMER_W'(WP_CYC - 1);
            end
         end
         ST_STROBE: begin
            timer_d = timer_q - 1'b1;
            if (timer_q == '0) begin
               state_d = ST_HOLD;
               timer_d = TIMER_W'(HOLD_CYC - 1);
            end
         end
         ST_HOLD: begin
            timer_d = timer_q - 1'b1;
            if (timer_q == '0) begin
               if (nxt != STEP_DONE) begin
                  step_d = nxt;
                  state_d = ST_SETUP;
                  timer_d = TIMER_W'(SETUP_CYC - 1);
               end else if (op_q == OP_RESET && erase_q) begin
                  state_d = ST_SETTLE;
                  timer_d = TIMER_W'(RST_WAIT_CYC - 1);
                  erase_d = 1'b0;
               end else begin
                  state_d = ST_IDLE;
                  if (op_q == OP_RESET) begin
                     erase_d = 1'b0;
                  end else if (op_q == OP_BLOCK_ERASE || op_q == OP_CHIP_ERASE ||
                               op_q == OP_ERASE_ADD) begin
                     erase_d = 1'b1;
                  end
               end
            end
         end
         ST_RD_WAIT: begin
            timer_d = timer_q - 1'b1;
            if (timer_q == '0) begin
               rdata_d = dq_sync; // Status or array data alike
               state_d = ST_IDLE;
            end
         end
         ST_SETTLE: begin
            timer_d = timer_q - 1'b1;
            if (timer_q == '0) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
      // Register writes land in the data phase
      if (wr_pend_q) begin
         case (addr_lat_q)
            REG_ADDR: addr_reg_d = hwdata[ADDR_W-1:0];
            REG_WDATA: wdata_d = hwdata[DATA_W-1:0];
            REG_CFG: cfg_d = hwdata[1:0];
            default: ;
         endcase
      end
      // Pins follow the next state so they leave straight from flops
      fa_d = fa_q;
      fdq_d = fdq_q;
      fdq_oe_n_d = 1'b1;
      ce_n_d = 1'b1;
      we_n_d = 1'b1;
      oe_n_d = 1'b1;
      case (state_d)
         ST_SETUP, ST_STROBE, ST_HOLD: begin
            fa_d = cyc_addr(step_d, cfg_q[CFG_WORD_BIT], op_d, addr_reg_q);
            fdq_d = cyc_data(step_d, op_d, wdata_q);
            fdq_oe_n_d = 1'b0;
            ce_n_d = 1'b0;
            we_n_d = (state_d != ST_STROBE);
         end
         ST_RD_WAIT: begin
            fa_d = addr_reg_q;
            ce_n_d = 1'b0;
            oe_n_d = 1'b0;
         end
         default: ;
      endcase
   end

   // ======================================================================
   // Registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= ST_IDLE;
         op_q <= OP_READ;
         step_q <= STEP_UNLOCK1;
         timer_q <= '0;
         erase_q <= 1'b0;
         addr_reg_q <= '0;
         wdata_q <= '0;
         rdata_q <= '0;
         cfg_q <= CFG_RESET;
         wr_pend_q <= 1'b0;
         addr_lat_q <= 8'h00;
         hrdata_q <= 32'h0000_0000;
         fa_q <= '0;
         fdq_q <= '0;
         fdq_oe_n_q <= 1'b1;
         ce_n_q <= 1'b1;
         we_n_q <= 1'b1;
         oe_n_q <= 1'b1;
         flash_byte_n <= 1'b0;
         hreadyout <= 1'b1;
         hresp <= HRESP_OKAY;
      end else begin
         state_q <= state_d;
         op_q <= op_d;
         step_q <= step_d;
         timer_q <= timer_d;
         erase_q <= erase_d;
         addr_reg_q <= addr_reg_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         cfg_q <= cfg_d;
         wr_pend_q <= wr_pend_d;
         addr_lat_q <= addr_lat_d;
         hrdata_q <= hrdata_d;
         fa_q <= fa_d;
         fdq_q <= fdq_d;
         fdq_oe_n_q <= fdq_oe_n_d;
         ce_n_q <= ce_n_d;
         we_n_q <= we_n_d;
         oe_n_q <= oe_n_d;
         flash_byte_n <= cfg_q[CFG_WORD_BIT];
         hreadyout <= 1'b1; // Zero wait states always
         hresp <= HRESP_OKAY;
      end
   end

   assign hrdata = hrdata_q;
   assign flash_addr = fa_q;
   assign flash_dq_out = fdq_q;
   assign flash_dq_oe_n = fdq_oe_n_q;
   assign flash_ce_n = ce_n_q;
   assign flash_we_n = we_n_q;
   assign flash_oe_n = oe_n_q;

   // ======================================================================
   // Assertions
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_strobe_low;
      !flash_we_n[*5];
   endsequence
   property p_we_width;
      $fell(flash_we_n) |-> s_strobe_low ##1 flash_we_n;
   endproperty
   a_we_width: assert property (p_we_width) else $error("write strobe width wrong");
   property p_write_drives;
      !flash_we_n |-> !flash_ce_n && !flash_dq_oe_n && flash_oe_n && $stable(flash_addr);
   endproperty
   a_write_drives: assert property (p_write_drives) else $error("bad write pins");
   property p_read_release;
      !flash_oe_n |-> flash_dq_oe_n && flash_we_n && !flash_ce_n && flash_addr == addr_reg_q;
   endproperty
   a_read_release: assert property (p_read_release) else $error("bad read pins");
   property p_unlock1;
      $fell(flash_we_n) && (step_q == STEP_UNLOCK1 || step_q == STEP_UNLOCK3) |->
         flash_dq_out == DATA_W'(CMD_UNLOCK1) && flash_addr == ADDR_W'(flash_byte_n ?
         ADDR_WORD_UNLOCK1 : ADDR_BYTE_UNLOCK1);
   endproperty
   a_unlock1: assert property (p_unlock1) else $error("first unlock wrong");
   property p_unlock2;
      $fell(flash_we_n) && step_q == STEP_UNLOCK2 |-> flash_dq_out == DATA_W'(CMD_UNLOCK2) &&
         flash_addr == ADDR_W'(flash_byte_n ? ADDR_WORD_UNLOCK2 : ADDR_BYTE_UNLOCK2);
   endproperty
   a_unlock2: assert property (p_unlock2) else $error("second unlock wrong");
   property p_prog_cmd;
      $fell(flash_we_n) && step_q == STEP_CMD && op_q == OP_PROGRAM |->
         flash_dq_out == DATA_W'(CMD_PROGRAM);
   endproperty
   a_prog_cmd: assert property (p_prog_cmd) else $error("program command wrong");
   property p_ident_cmd;
      $fell(flash_we_n) && step_q == STEP_CMD && op_q == OP_IDENT |->
         flash_dq_out == DATA_W'(CMD_IDENT);
   endproperty
   a_ident_cmd: assert property (p_ident_cmd) else $error("identify command wrong");
   property p_reset_cmd;
      $fell(flash_we_n) && op_q == OP_RESET |-> step_q != STEP_CMD ||
         flash_dq_out == DATA_W'(CMD_RESET);
   endproperty
   a_reset_cmd: assert property (p_reset_cmd) else $error("reset command wrong");
   property p_block_confirm;
      $fell(flash_we_n) && step_q == STEP_FINAL && op_q == OP_BLOCK_ERASE |->
         flash_dq_out == DATA_W'(CMD_BLOCK_CONFIRM) && flash_addr == addr_reg_q;
   endproperty
   a_block_confirm: assert property (p_block_confirm) else $error("block confirm wrong");
   property p_chip_confirm;
      $fell(flash_we_n) && step_q == STEP_FINAL && op_q == OP_CHIP_ERASE |->
         flash_dq_out == DATA_W'(CMD_CHIP_CONFIRM);
   endproperty
   a_chip_confirm: assert property (p_chip_confirm) else $error("chip confirm wrong");
   property p_settle;
      $rose(state_q == ST_SETTLE) |-> timer_q == TIMER_W'(RST_WAIT_CYC - 1) &&
         flash_ce_n && (state_q == ST_SETTLE)[*8];
   endproperty
   a_settle: assert property (p_settle) else $error("reset settle wait wrong");
endmodule

// >>> verification/flash_dev_model.sv
// Behavioural parallel flash device seen from its pins
`timescale 1ns/1ns
module flash_dev_model #(
   parameter logic [15:0] MFG_ID = 16'h003C, // Arbitrary value
   parameter logic [15:0] DEV_ID = 16'h007E // Arbitrary value
) (
   // Flash pins
   input wire logic [17:0] a,
   input wire logic [15:0] dq_w,
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic byte_n,
   output logic [15:0] dq_r
);
   // =====================================================================
   // State
   logic [15:0] mem [int];
   logic [15:0] rdv;
   logic [15:0] last = 16'h5A5A;
   logic [17:0] la, u1, u2;
   logic [7:0] d;
   int st;
   bit id, q;
   // Unlock addresses follow the organisation pin
   assign u1 = byte_n ? 18'h0_5555 : 18'h0_AAAA;
   assign u2 = byte_n ? 18'h0_2AAA : 18'h0_5555;
   // Read data; identify mode replaces the array
   always @(a or id or oe_n) begin
      if (id) begin
         rdv = (a[1:0] == 2'h0) ? MFG_ID : (a[1:0] == 2'h1) ? DEV_ID : 16'h0000;
      end else begin
         rdv = mem.exists(a) ? mem[a] : 16'hFFFF;
      end
   end
   // Released bus shows the inverse, so a stale value never passes
   always @(posedge oe_n) last = rdv;
   assign dq_r = (!ce_n && !oe_n) ? rdv : ~last;
   // Erase finishes at once; the internal pre-program to 00h is invisible
   task automatic ers(input logic [17:0] b);
      foreach (mem[k]) if (k[17:12] == b[17:12]) mem[k] = 16'hFFFF;
   endtask
   // Address on the strobe fall, data and decode on the rise
   always @(negedge we_n) la = a;
   always @(posedge we_n) begin
      d = dq_w[7:0];
      if (!ce_n && st != 3 && d == 8'hF0) begin
         st = 0;
         id = 0;
         q = 0;
      end else if (!ce_n) begin
         case (st)
            0: begin
               if (q && d == 8'h30) ers(la);
               else q = 0;
               st = (la == u1 && d == 8'hAA) ? 1 : 0;
            end
            1: st = (la == u2 && d == 8'h55) ? 2 : 0;
            2: begin
               id = id | (la == u1 && d == 8'h90);
               st = (la != u1) ? 0 : (d == 8'hA0) ? 3 : (d == 8'h80) ? 4 : 0;
            end
            3: begin
               mem[la] = (mem.exists(la) ? mem[la] : 16'hFFFF) & dq_w;
               st = 0;
            end
            4: st = (la == u1 && d == 8'hAA) ? 5 : 0;
            5: st = (la == u2 && d == 8'h55) ? 6 : 0;
            default: begin
               if (d == 8'h30) ers(la);
               if (d == 8'h10) mem.delete();
               q = (d == 8'h30);
               st = 0;
            end
         endcase
      end
   end
endmodule

// >>> verification/flash_host_ctrl_tb.sv
// Bench: host controller driving a flash model, checked against a reference
`timescale 1ns/1ns
module flash_host_ctrl_tb import flash_host_pkg::*; ;
   // =====================================================================
   // Signals
   localparam logic [15:0] MFG = 16'h003C; // Arbitrary value
   localparam logic [15:0] DEV = 16'h007E; // Arbitrary value
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, wm, unl;
   logic flash_dq_oe_n, flash_ce_n, flash_we_n, flash_oe_n, flash_byte_n;
   logic [31:0] haddr, hwdata, hrdata, seed, r, st0;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [17:0] flash_addr, a, u1;
   logic [15:0] flash_dq_out, flash_dq_in, d, mk;
   logic [27:0] wq [$], eq [$];
   logic [15:0] ref_m [int];
   int n_errors, total_checks, polls;
   assign u1 = wm ? ADDR_WORD_UNLOCK1 : ADDR_BYTE_UNLOCK1;
   assign mk = wm ? 16'hFFFF : 16'h00FF;
   flash_host_ctrl flash_host_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
      .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
      .flash_oe_n(flash_oe_n), .flash_byte_n(flash_byte_n));
   flash_dev_model #(.MFG_ID(MFG), .DEV_ID(DEV)) flash_dev_model_i (.a(flash_addr),
      .dq_w(flash_dq_out), .ce_n(flash_ce_n), .we_n(flash_we_n), .oe_n(flash_oe_n),
      .byte_n(flash_byte_n), .dq_r(flash_dq_in));
   // =====================================================================
   // Clock, write log and helpers
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // Each strobe rise is logged with chip select and drive enable
   always @(posedge flash_we_n) if (hresetn === 1'b1)
      wq.push_back({flash_ce_n, flash_dq_oe_n, flash_addr, flash_dq_out[7:0]});
   task automatic end_sim();
      if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [15:0] get(input logic [17:0] k);
      return ref_m.exists(k) ? ref_m[k] : 16'hFFFF;
   endfunction
   function automatic void p(input logic [17:0] ad, input logic [7:0] v);
      eq.push_back({2'b00, ad, v});
   endfunction
   function automatic void ul();
      p(u1, CMD_UNLOCK1);
      p(wm ? ADDR_WORD_UNLOCK2 : ADDR_BYTE_UNLOCK2, CMD_UNLOCK2);
   endfunction
   // One AHB single transfer; read data lands in r
   task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {24'h00_0000, ad};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   // Order one operation, wait for idle, compare the pin write sequence
   task automatic op(input int o, input logic [17:0] ad, input logic [15:0] v);
      eq = {};
      if (o != 0 && o != 5 && o != 7 && (o != 1 || unl)) ul();
      if (o == 1) p(18'h3_FFFF, CMD_RESET);
      if (o == 2) p(u1, CMD_IDENT);
      if (o == 3) p(u1, CMD_PROGRAM);
      if (o == 4 || o == 6) p(u1, CMD_ERASE_SETUP);
      if (o == 4 || o == 6) ul();
      if (o == 3 || o == 7) p(ad, v[7:0]);
      if (o == 4 || o == 5) p(ad, CMD_BLOCK_CONFIRM);
      if (o == 6) p(u1, CMD_CHIP_CONFIRM);
      wq = {};
      st0 = 32'h0;
      polls = 0;
      bus(1'b1, REG_ADDR, {14'h0000, ad});
      bus(1'b1, REG_WDATA, {16'h0000, v});
      chk("byte_n", {31'h0, flash_byte_n}, {31'h0, wm});
      bus(1'b1, REG_CMD, 32'(o));
      do begin
         bus(1'b0, REG_STATUS, 32'h0);
         st0 = st0 | r;
         polls++;
      end while (r[ST_BUSY_BIT] !== 1'b0 && polls < 2000);
      // A poll limit that runs out must count as a mismatch, not pass quietly
      chk("busy", {31'h0, r[ST_BUSY_BIT]}, 32'h0);
      chk("n_wr", wq.size(), eq.size());
      foreach (eq[i]) begin
         if (eq[i][25:8] === 18'h3_FFFF) eq[i][25:8] = wq[i][25:8];
         chk("wr", wq[i], {4'h0, eq[i]});
      end
   endtask
   task automatic rb(input logic [17:0] ad, input logic [15:0] e);
      op(0, ad, 16'h0000);
      bus(1'b0, REG_RDATA, 32'h0);
      chk("rdata", {16'h0, r[15:0] & mk}, {16'h0, e & mk});
   endtask
   // =====================================================================
   // Main sequence: byte mode plain reset, then word mode unlocked reset
   initial begin
      seed = 32'h80d9_6fad;
      {hsel, hwrite, htrans, haddr, hwdata, wm, unl} = '0;
      hsize = 3'h2;
      hresetn = 1'b0;
      repeat (20) @(posedge hclk);
      chk("rst", {flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe_n, hreadyout, hresp}, 32'h3E);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int m = 0; m < 2; m++) begin
         wm = m[0];
         unl = m[0];
         bus(1'b1, REG_CFG, {30'h0, unl, wm});
         a = 18'(rnd());
         for (int k = 0; k < 2; k++) begin
            d = 16'(rnd());
            op(3, a, d);
            ref_m[a] = get(a) & d;
            rb(a, get(a));
         end
         op(2, 18'h0, 16'h0);
         for (int k = 0; k < 3; k++) begin
            rb({a[17:12], 10'h000, k[1:0]}, k == 0 ? MFG : k == 1 ? DEV : 16'h0000);
         end
         op(1, 18'h0, 16'h0);
         rb(a, get(a));
         op(4, a, 16'h0);
         op(5, a ^ 18'h1_0000, 16'h0);
         ref_m.delete();
         rb(a, 16'hFFFF);
         op(1, 18'h0, 16'h0);
         chk("settle", {31'h0, st0[ST_SETTLE_BIT]}, 32'h1);
         chk("settle_len", 32'(polls >= 500), 32'h1);
         op(7, a, 16'h005A);
         rb(a, 16'hFFFF);
         op(6, 18'h0, 16'h0);
      end
      end_sim();
   end
   // Watchdog well beyond the expected run of a few thousand cycles
   initial begin
      #500_000;
      n_errors++;
      end_sim();
   end
endmodule
